// [src/pc_card_address_decoder.sv]
`timescale 1ns/1ps
module pc_card_address_decoder (
    // Clock, reset, enable
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    // Host socket pins
    input  wire addr_dec_pkg::host_req_s    host_i,
    input  wire logic                       nvm_select_strap_i,
    output logic                            wait_n_o,
    output logic [7:0]                      rdata_o,
    // On-chip status and mode
    input  wire logic                       shared_mode_i,
    input  wire logic                       autoload_done_i,
    input  wire logic                       intr_i,
    input  wire logic [15:0]                core_addr_i,
    // Target steering
    output addr_dec_pkg::target_req_s       tgt_o,
    output addr_dec_pkg::core_map_s         core_map_o,
    output logic                            core_rst_o,
    output logic                            flash_not_eeprom_select_o,
    output logic [7:0]                      lan_config_a_o,
    output logic [7:0]                      lan_config_b_o
);

    addr_dec_pkg::state_s st;
    addr_dec_pkg::state_s next_st;

    logic        active;
    logic        accept;
    logic [16:0] maddr;
    logic [16:0] img_addr;

    // Card register hit at an attribute offset
    // Reserved offsets between them stay unmatched on purpose
    function automatic logic is_card_reg(input logic [16:0] a);
        return a == addr_dec_pkg::OFS_CARD_OPTION
            || a == addr_dec_pkg::OFS_CARD_CFG_STAT
            || a == addr_dec_pkg::OFS_SOCKET_COPY
            || a == addr_dec_pkg::OFS_LAN_CFG_A
            || a == addr_dec_pkg::OFS_LAN_CFG_B
            || a == addr_dec_pkg::OFS_SPECIAL_STAT;
    endfunction

    // Attribute space decode for either strap setting
    // Card registers sit in both maps and are matched first
    // Holes between the listed ranges fall through to no target
    // The image is hidden until autoload has filled the SRAM
    function automatic addr_dec_pkg::target_e attr_target(
        input logic [16:0] a,
        input logic        strap,
        input logic        loaded
    );
        addr_dec_pkg::target_e t;
        t = addr_dec_pkg::TGT_NONE;
        if (is_card_reg(a)) begin
            t = addr_dec_pkg::TGT_CARD_REG;
        end else if (strap) begin
            if (a <= addr_dec_pkg::ATTR_CIS_LO_END) begin
                t = addr_dec_pkg::TGT_FLASH;
            end else if (a >= addr_dec_pkg::ATTR_RSV_LO
                         && a <= addr_dec_pkg::ATTR_ID_END) begin
                t = addr_dec_pkg::TGT_FLASH;
            end else if (a >= addr_dec_pkg::ATTR_CIS_HI_LO
                         && a <= addr_dec_pkg::ATTR_CIS_HI_END) begin
                t = addr_dec_pkg::TGT_FLASH;
            end
        end else if (a <= addr_dec_pkg::ATTR_IMG_END && loaded) begin
            t = addr_dec_pkg::TGT_SRAM;
        end
        return t;
    endfunction

    // Common space decode
    // The shared SRAM window wins over the flash window
    // Strap low: no flash fitted, so only shared SRAM answers
    function automatic addr_dec_pkg::target_e common_target(
        input logic [16:0] a,
        input logic        strap,
        input logic        shared
    );
        addr_dec_pkg::target_e t;
        t = addr_dec_pkg::TGT_NONE;
        if (shared && a <= addr_dec_pkg::COMMON_SRAM_END) begin
            t = addr_dec_pkg::TGT_SRAM;
        end else if (strap && a >= addr_dec_pkg::COMMON_FLASH_LO) begin
            t = addr_dec_pkg::TGT_FLASH;
        end
        return t;
    endfunction

    // I/O space decode on five address bits
    // Compatible map: three ranges cover all 32 offsets
    // Shared map: offsets 02-04 and 06-07 have no target
    function automatic addr_dec_pkg::target_e io_target(
        input logic [4:0] a,
        input logic       shared
    );
        addr_dec_pkg::target_e t;
        t = addr_dec_pkg::TGT_NONE;
        if (!shared) begin
            if (a < addr_dec_pkg::IO_RDMA_LO) begin
                t = addr_dec_pkg::TGT_CORE;
            end else if (a < addr_dec_pkg::IO_RESET_LO) begin
                t = addr_dec_pkg::TGT_RDMA;
            end else begin
                t = addr_dec_pkg::TGT_RESET;
            end
        end else if (a >= addr_dec_pkg::IO_RDMA_LO) begin
            t = addr_dec_pkg::TGT_CORE;
        end else if (a >= addr_dec_pkg::IO_ID_LO) begin
            t = addr_dec_pkg::TGT_ID;
        end else if (a == addr_dec_pkg::IO_MAP_CTRL_A
                     || a == addr_dec_pkg::IO_MAP_CTRL_B) begin
            t = addr_dec_pkg::TGT_MAP_CTRL;
        end else if (a == addr_dec_pkg::IO_BUS_WIDTH) begin
            t = addr_dec_pkg::TGT_BUS_WIDTH;
        end
        return t;
    endfunction

    // Host cycle in progress and its acceptance
    // A strobe is taken once, never while the core is in reset,
    // and not before the strap has been caught
    assign active = st.sync2.mem_rd | st.sync2.mem_wr
                  | st.sync2.io_rd | st.sync2.io_wr;
    assign accept = active & ~st.taken & (st.rst_cnt == 8'h00)
                  & st.strap_taken;
    assign maddr  = st.sync2.addr;
    assign img_addr = 17'(addr_dec_pkg::SRAM_IMAGE_BASE) + maddr;

    // Next-state logic
    // Target is picked every cycle but only latched on accept
    always_comb begin
        addr_dec_pkg::target_e t;
        t = addr_dec_pkg::TGT_NONE;
        next_st = st;
        // Two-stage synchronisers for the host pins and the strap
        // Address and data ride with the strobes, held by the host
        next_st.sync1 = host_i;
        next_st.sync2 = st.sync1;
        next_st.strap_sync1 = nvm_select_strap_i;
        next_st.strap_sync2 = st.strap_sync1;
        // Strap caught once after reset release
        // The map then stays put until the next hardware reset
        if (!st.strap_taken) begin
            next_st.strap_taken = 1'b1;
            next_st.nvm_strap = st.strap_sync2;
        end
        // Pick the target of the current host cycle
        if (st.sync2.io_rd | st.sync2.io_wr) begin
            t = io_target(st.sync2.addr[4:0], shared_mode_i);
        end else if (st.sync2.attr) begin
            if (maddr <= addr_dec_pkg::ATTR_TOP) begin
                t = attr_target(maddr, st.nvm_strap, autoload_done_i);
            end
        end else begin
            t = common_target(maddr, st.nvm_strap, shared_mode_i);
        end
        // Default: no strobe this cycle
        // Taken stays set until the synced strobe drops
        next_st.out.rd = 1'b0;
        next_st.out.wr = 1'b0;
        next_st.taken = active & (st.taken | accept);
        if (accept) begin
            next_st.out.target = t;
            next_st.out.wdata = st.sync2.wdata;
            next_st.out.addr = maddr;
            if (st.sync2.io_rd | st.sync2.io_wr) begin
                next_st.out.addr = {12'h000, maddr[4:0]};
            end else if (t == addr_dec_pkg::TGT_SRAM && st.sync2.attr) begin
                next_st.out.addr = img_addr;
            end
            // Image writes give no pulse: the SRAM copy is read-only
            next_st.out.rd = (st.sync2.mem_rd | st.sync2.io_rd)
                           & (t != addr_dec_pkg::TGT_NONE);
            next_st.out.wr = (st.sync2.mem_wr | st.sync2.io_wr)
                           & (t != addr_dec_pkg::TGT_NONE)
                           & ~(t == addr_dec_pkg::TGT_SRAM
                               && st.sync2.attr);
            // Anything but a local register reads back as zero
            next_st.rdata = addr_dec_pkg::REG_RESET;
            // Local register reads
            if (t == addr_dec_pkg::TGT_BUS_WIDTH) begin
                next_st.rdata = addr_dec_pkg::BUS_WIDTH_VALUE;
            end else if (t == addr_dec_pkg::TGT_CARD_REG) begin
                unique case (maddr)
                    addr_dec_pkg::OFS_CARD_OPTION: begin
                        next_st.rdata = st.card_option_reg;
                        next_st.rdata[addr_dec_pkg::OPTION_LEVEL_BIT] = 1'b1;
                    end
                    addr_dec_pkg::OFS_CARD_CFG_STAT: begin
                        next_st.rdata = {6'h00, intr_i, 1'b0};
                    end
                    addr_dec_pkg::OFS_SOCKET_COPY: begin
                        next_st.rdata = st.socket_copy_reg;
                    end
                    addr_dec_pkg::OFS_LAN_CFG_A: begin
                        next_st.rdata = st.lan_config_a_reg;
                    end
                    addr_dec_pkg::OFS_LAN_CFG_B: begin
                        next_st.rdata = st.lan_config_b_reg;
                    end
                    default: begin
                        next_st.rdata = st.special_status_reg;
                    end
                endcase
            end
            // Local register writes
            if (st.sync2.mem_wr && t == addr_dec_pkg::TGT_CARD_REG) begin
                unique case (maddr)
                    addr_dec_pkg::OFS_CARD_OPTION: begin
                        next_st.card_option_reg = st.sync2.wdata;
                    end
                    addr_dec_pkg::OFS_SOCKET_COPY: begin
                        next_st.socket_copy_reg = st.sync2.wdata;
                    end
                    addr_dec_pkg::OFS_LAN_CFG_A: begin
                        next_st.lan_config_a_reg = st.sync2.wdata;
                    end
                    addr_dec_pkg::OFS_LAN_CFG_B: begin
                        next_st.lan_config_b_reg = st.sync2.wdata;
                    end
                    addr_dec_pkg::OFS_SPECIAL_STAT: begin
                        next_st.special_status_reg = st.sync2.wdata;
                    end
                    default: begin
                    end
                endcase
            end
            if (st.sync2.io_wr && t == addr_dec_pkg::TGT_MAP_CTRL) begin
                if (st.sync2.addr[4:0] == addr_dec_pkg::IO_MAP_CTRL_A) begin
                    next_st.shared_map_ctrl_a = st.sync2.wdata;
                end else begin
                    next_st.shared_map_ctrl_b = st.sync2.wdata;
                end
            end
            // Reset port read starts the internal reset pulse
            // Accept is blocked while it runs, so it cannot retrigger
            if (st.sync2.io_rd && t == addr_dec_pkg::TGT_RESET) begin
                next_st.rst_cnt = 8'(addr_dec_pkg::RESET_CYCLES);
            end
        end else if (st.rst_cnt != 8'h00) begin
            next_st.rst_cnt = st.rst_cnt - 8'h01;
        end
        next_st.core_rst = (next_st.rst_cnt != 8'h00);
        // Hold the host off while the core is in reset
        // The next count is used so wait drops with the pulse
        next_st.wait_n = ~(active & (next_st.rst_cnt != 8'h00));
        // Core local map in compatible mode
        // Bit 14 splits SRAM from ID registers; higher bits alias
        next_st.core_map.core_sram_sel = ~shared_mode_i
                                       & core_addr_i[14];
        next_st.core_map.core_id_sel = ~shared_mode_i
                                     & ~core_addr_i[14];
        next_st.core_map.core_sram_addr = core_addr_i[13:0];
    end

    // State register
    // Low clock enable freezes every field, synchronisers included
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.wait_n <= 1'b1;
            st.out.target <= addr_dec_pkg::TGT_NONE;
            // Strap synchroniser runs through reset so it has settled
            st.strap_sync1 <= next_st.strap_sync1;
            st.strap_sync2 <= next_st.strap_sync2;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    // Shared map controls are write-only and kept internal
    assign tgt_o                     = st.out;
    assign rdata_o                   = st.rdata;
    assign wait_n_o                  = st.wait_n;
    assign core_rst_o                = st.core_rst;
    assign core_map_o                = st.core_map;
    assign flash_not_eeprom_select_o = st.nvm_strap;
    assign lan_config_a_o            = st.lan_config_a_reg;
    assign lan_config_b_o            = st.lan_config_b_reg;

endmodule

// [common/addr_dec_pkg.sv]
package addr_dec_pkg;

    // Attribute memory regions
    localparam logic [16:0] ATTR_CIS_LO_END   = 17'h00F9E;
    localparam logic [16:0] ATTR_RSV_LO       = 17'h00FA0;
    localparam logic [16:0] ATTR_ID_END       = 17'h00FC2;
    localparam logic [16:0] ATTR_RSV_HI       = 17'h00FFE;
    localparam logic [16:0] ATTR_CIS_HI_LO    = 17'h01000;
    localparam logic [16:0] ATTR_CIS_HI_END   = 17'h03FFE;
    localparam logic [16:0] ATTR_IMG_END      = 17'h003D6;
    localparam logic [16:0] ATTR_TOP          = 17'h03FFF;
    // Common memory regions
    localparam logic [16:0] COMMON_SRAM_END   = 17'h03FFF;
    localparam logic [16:0] COMMON_FLASH_LO   = 17'h04000;
    localparam logic [16:0] COMMON_FLASH_END  = 17'h1FFFF;
    // Card register offsets
    localparam logic [16:0] OFS_CARD_OPTION   = 17'h00FD0;
    localparam logic [16:0] OFS_CARD_CFG_STAT = 17'h00FD2;
    localparam logic [16:0] OFS_SOCKET_COPY   = 17'h00FD6;
    localparam logic [16:0] OFS_LAN_CFG_A     = 17'h00FF0;
    localparam logic [16:0] OFS_LAN_CFG_B     = 17'h00FF2;
    localparam logic [16:0] OFS_SPECIAL_STAT  = 17'h00FF4;
    // I/O offsets
    localparam logic [4:0]  IO_RDMA_LO        = 5'h10;
    localparam logic [4:0]  IO_RESET_LO       = 5'h18;
    localparam logic [4:0]  IO_MAP_CTRL_A     = 5'h00;
    localparam logic [4:0]  IO_BUS_WIDTH      = 5'h01;
    localparam logic [4:0]  IO_MAP_CTRL_B     = 5'h05;
    localparam logic [4:0]  IO_ID_LO          = 5'h08;
    localparam logic [7:0]  BUS_WIDTH_VALUE   = 8'h01;
    // SRAM image base: upper half of a 32K SRAM
    localparam logic [14:0] SRAM_IMAGE_BASE   = 15'h4000;
    // Reset values
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam int          OPTION_LEVEL_BIT  = 6;
    // Internal reset pulse
    localparam int          RESET_PULSE_NS    = 600;
    localparam int          CLK_MHZ           = 250;
    localparam int          RESET_CYCLES      =
        (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        TGT_NONE, TGT_FLASH, TGT_SRAM, TGT_CARD_REG, TGT_CORE,
        TGT_RDMA, TGT_RESET, TGT_ID, TGT_MAP_CTRL, TGT_BUS_WIDTH
    } target_e;

    typedef struct packed {
        logic        mem_rd;
        logic        mem_wr;
        logic        io_rd;
        logic        io_wr;
        logic        attr;
        logic [16:0] addr;
        logic [7:0]  wdata;
    } host_req_s;

    typedef struct packed {
        target_e     target;
        logic        rd;
        logic        wr;
        logic [16:0] addr;
        logic [7:0]  wdata;
    } target_req_s;

    typedef struct packed {
        logic        core_sram_sel;
        logic        core_id_sel;
        logic [13:0] core_sram_addr;
    } core_map_s;

    typedef struct packed {
        host_req_s   sync1;
        host_req_s   sync2;
        logic        strap_sync1;
        logic        strap_sync2;
        logic        strap_taken;
        logic        nvm_strap;
        logic        taken;
        logic [7:0]  card_option_reg;
        logic [7:0]  socket_copy_reg;
        logic [7:0]  lan_config_a_reg;
        logic [7:0]  lan_config_b_reg;
        logic [7:0]  special_status_reg;
        logic [7:0]  shared_map_ctrl_a;
        logic [7:0]  shared_map_ctrl_b;
        logic [7:0]  rst_cnt;
        target_req_s out;
        logic [7:0]  rdata;
        logic        wait_n;
        logic        core_rst;
        core_map_s   core_map;
    } state_s;

endpackage

// [bench/addr_dec_chk.sv]
`timescale 1ns/1ps
module addr_dec_chk (
    // Clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    // Watched ports
    input wire addr_dec_pkg::host_req_s   host_i,
    input wire logic                      shared_mode_i,
    input wire logic [15:0]               core_addr_i,
    input wire logic                      wait_n_o,
    input wire logic [7:0]                rdata_o,
    input wire addr_dec_pkg::target_req_s tgt_o,
    input wire addr_dec_pkg::core_map_s   core_map_o,
    input wire logic                      core_rst_o,
    input wire logic                      flash_not_eeprom_select_o
);
    logic [7:0]  hi_cnt;
    logic        busy;
    logic        io_on;
    logic        pulse;
    logic        a14;
    logic [13:0] c13;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Strobe, pulse and core address taps
    assign busy  = host_i.mem_rd | host_i.mem_wr | io_on;
    assign io_on = host_i.io_rd | host_i.io_wr;
    assign pulse = tgt_o.rd | tgt_o.wr;
    assign a14   = core_addr_i[14];
    assign c13   = core_addr_i[13:0];
    // Cycles the internal reset has stayed high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !core_rst_o)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= hi_cnt + 8'h01;
    end
    a_rst_len: assert property ($fell(core_rst_o) |-> hi_cnt == 8'h96)
        else $error("internal reset length wrong");
    a_rst_start: assert property ((tgt_o.rd &&
        tgt_o.target == addr_dec_pkg::TGT_RESET) |-> core_rst_o)
        else $error("reset port read gave no reset");
    a_wait_why: assert property (!wait_n_o |->
        core_rst_o || $past(core_rst_o))
        else $error("wait low without reset");
    a_wait_hold: assert property ((busy && core_rst_o) [*5] |->
        !wait_n_o)
        else $error("wait not low during reset");
    a_one_pulse: assert property (pulse |->
        !(tgt_o.rd && tgt_o.wr) ##1 !pulse)
        else $error("target pulse too long");
    a_no_none: assert property (pulse |->
        tgt_o.target != addr_dec_pkg::TGT_NONE)
        else $error("pulse to unused region");
    a_width_val: assert property ((tgt_o.rd &&
        tgt_o.target == addr_dec_pkg::TGT_BUS_WIDTH) |-> rdata_o == 8'h01)
        else $error("bus width value wrong");
    a_io_narrow: assert property ((pulse && $past(io_on, 3)) |->
        tgt_o.addr[16:5] == 12'h000)
        else $error("io address not narrowed");
    a_strap_hold: assert property ((rst_n_i && $past(rst_n_i, 3)) |->
        $stable(flash_not_eeprom_select_o))
        else $error("strap map changed");
    a_core_map: assert property ($past(rst_n_i) |-> core_map_o ==
        {!$past(shared_mode_i) && $past(a14),
         !$past(shared_mode_i) && !$past(a14), $past(c13)})
        else $error("core map wrong");
endmodule
bind pc_card_address_decoder addr_dec_chk addr_dec_chk_i (
    .clk_i                     (clk_i),
    .rst_n_i                   (rst_n_i),
    .host_i                    (host_i),
    .shared_mode_i             (shared_mode_i),
    .core_addr_i               (core_addr_i),
    .wait_n_o                  (wait_n_o),
    .rdata_o                   (rdata_o),
    .tgt_o                     (tgt_o),
    .core_map_o                (core_map_o),
    .core_rst_o                (core_rst_o),
    .flash_not_eeprom_select_o (flash_not_eeprom_select_o)
);

// [bench/host_socket_model.sv]
`timescale 1ns/1ps
module host_socket_model (
    // Clock
    input  wire logic               clk_i,
    // Card side
    input  wire logic               wait_n_i,
    output addr_dec_pkg::host_req_s host_o
);
    // Idle socket at start
    initial host_o = '0;
    // One byte cycle; edges with wait low do not count toward the hold
    task automatic cycle(input logic [3:0] kind, input logic attr,
                         input logic [16:0] addr, input logic [7:0] wdata);
        int n;
        int lim;
        n = 0;
        lim = 0;
        host_o = '{kind[3], kind[2], kind[1], kind[0], attr, addr, wdata};
        while (n < 5 && lim < 400) begin
            @(posedge clk_i);
            lim++;
            if (wait_n_i === 1'b1)
                n++;
        end
        #1;
        // Released lines stop showing the last value
        host_o = '{1'b0, 1'b0, 1'b0, 1'b0, ~attr, ~addr, ~wdata};
        repeat (3) @(posedge clk_i);
        #1;
    endtask
endmodule

// [bench/pc_card_address_decoder_tb.sv]
`timescale 1ns/1ps
module pc_card_address_decoder_tb;
    typedef struct packed {
        addr_dec_pkg::target_e t;
        logic                  rd;
        logic [16:0]           a;
        logic [7:0]            d;
    } exp_s;
    localparam logic [3:0] MR = 4'h8;
    localparam logic [3:0] MW = 4'h4;
    localparam logic [3:0] IR = 4'h2;
    localparam logic [3:0] IW = 4'h1;
    logic                      clk_i;
    logic                      rst_n_i;
    logic                      strap;
    logic                      shared;
    logic                      loaded;
    logic                      intr;
    logic [15:0]               core_addr;
    logic                      wait_n;
    logic [7:0]                rdata;
    logic                      core_rst;
    logic                      fsel;
    logic [7:0]                cfg_a;
    logic [7:0]                cfg_b;
    addr_dec_pkg::host_req_s   host;
    addr_dec_pkg::target_req_s tgt;
    int                        err_total;
    int                        tests_run;
    int                        wait_lo;
    exp_s                      q[$];
    exp_s                      e;
    pc_card_address_decoder pc_card_address_decoder_i (
        .clk_i                     (clk_i),
        .rst_n_i                   (rst_n_i),
        .ce_i                      (1'b1),
        .host_i                    (host),
        .nvm_select_strap_i        (strap),
        .wait_n_o                  (wait_n),
        .rdata_o                   (rdata),
        .shared_mode_i             (shared),
        .autoload_done_i           (loaded),
        .intr_i                    (intr),
        .core_addr_i               (core_addr),
        .tgt_o                     (tgt),
        .core_map_o                (),
        .core_rst_o                (core_rst),
        .flash_not_eeprom_select_o (fsel),
        .lan_config_a_o            (cfg_a),
        .lan_config_b_o            (cfg_b)
    );
    host_socket_model host_socket_model_i (
        .clk_i    (clk_i),
        .wait_n_i (wait_n),
        .host_o   (host)
    );
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic reset_dut();
        rst_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        @(posedge clk_i);
        #1;
    endtask
    // Notes the expected pulse, then runs one host cycle
    task automatic go(input logic [3:0] k, input logic at,
                      input logic [16:0] a, input logic [7:0] d,
                      input addr_dec_pkg::target_e t, input logic [7:0] er);
        logic [31:0] r;
        logic [16:0] ea;
        r = $urandom;
        if (k[1] | k[0]) begin
            a[16:5] = r[11:0];
            ea = {12'h000, a[4:0]};
        end else if (at && t == addr_dec_pkg::TGT_SRAM)
            ea = a + {2'b00, addr_dec_pkg::SRAM_IMAGE_BASE};
        else
            ea = a;
        if (t != addr_dec_pkg::TGT_NONE)
            q.push_back('{t, k[3] | k[1], ea, (k[3] | k[1]) ? er : d});
        host_socket_model_i.cycle(k, at, a, d);
    endtask
    // Random core address every cycle
    always @(posedge clk_i) begin
        #1;
        core_addr = 16'($urandom);
    end
    // Pairs each target pulse with the oldest note
    always @(posedge clk_i) begin
        #1;
        if (wait_n === 1'b0)
            wait_lo++; // Cycles the host is held off
        if (tgt.rd === 1'b1 || tgt.wr === 1'b1) begin
            if (q.size() == 0)
                check("unexpected pulse", 32'h0, 32'h1);
            else begin
                e = q.pop_front();
                check("target", e.t, tgt.target);
                check("rd", e.rd, tgt.rd);
                check("wr", !e.rd, tgt.wr);
                check("addr", e.a, tgt.addr);
                if (e.rd)
                    check("rdata", e.d, rdata);
                else
                    check("wdata", e.d, tgt.wdata);
            end
        end
    end
    // Watchdog
    initial begin
        repeat (4000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
    // Main sequence; reserved attribute registers are never touched
    initial begin
        void'($urandom(32'h601C45BC));
        err_total = 0;
        tests_run = 0;
        wait_lo = 0;
        strap = 1'b1;
        shared = 1'b0;
        loaded = 1'b1;
        intr = 1'b1;
        core_addr = 16'h0000;
        reset_dut();
        check("strap map", 32'h1, fsel);
        go(MR, 1, 17'h00F9E, 8'h00, addr_dec_pkg::TGT_FLASH, 8'h00);
        go(MR, 1, 17'h03FFE, 8'h00, addr_dec_pkg::TGT_FLASH, 8'h00);
        go(MW, 1, 17'h00FD0, 8'h05, addr_dec_pkg::TGT_CARD_REG, 8'h00);
        go(MR, 1, 17'h00FD0, 8'h00, addr_dec_pkg::TGT_CARD_REG, 8'h45);
        go(MR, 1, 17'h00FD2, 8'h00, addr_dec_pkg::TGT_CARD_REG, 8'h02);
        go(MW, 1, 17'h00FF0, 8'h5A, addr_dec_pkg::TGT_CARD_REG, 8'h00);
        check("lan cfg a", 32'h5A, cfg_a);
        go(MW, 1, 17'h00FF2, 8'hC3, addr_dec_pkg::TGT_CARD_REG, 8'h00);
        check("lan cfg b", 32'hC3, cfg_b);
        go(MR, 1, 17'h00FF0, 8'h00, addr_dec_pkg::TGT_CARD_REG, 8'h5A);
        go(MR, 1, 17'h04000, 8'h00, addr_dec_pkg::TGT_NONE, 8'h00);
        go(MR, 0, 17'h1FFFF, 8'h00, addr_dec_pkg::TGT_FLASH, 8'h00);
        go(MR, 0, 17'h01234, 8'h00, addr_dec_pkg::TGT_NONE, 8'h00);
        go(IW, 0, 17'h0000F, 8'h33, addr_dec_pkg::TGT_CORE, 8'h00);
        go(IR, 0, 17'h00010, 8'h00, addr_dec_pkg::TGT_RDMA, 8'h00);
        go(IW, 0, 17'h00017, 8'h11, addr_dec_pkg::TGT_RDMA, 8'h00);
        go(IR, 0, 17'h00018, 8'h00, addr_dec_pkg::TGT_RESET, 8'h00);
        check("wait cycles", addr_dec_pkg::RESET_CYCLES, wait_lo);
        go(MR, 1, 17'h00F9E, 8'h00, addr_dec_pkg::TGT_FLASH, 8'h00);
        shared = 1'b1;
        go(IW, 0, 17'h00000, 8'hC0, addr_dec_pkg::TGT_MAP_CTRL, 8'h00);
        go(IW, 0, 17'h00005, 8'h00, addr_dec_pkg::TGT_MAP_CTRL, 8'h00);
        go(IR, 0, 17'h00001, 8'h00, addr_dec_pkg::TGT_BUS_WIDTH, 8'h01);
        go(IR, 0, 17'h00008, 8'h00, addr_dec_pkg::TGT_ID, 8'h00);
        go(IR, 0, 17'h0001F, 8'h00, addr_dec_pkg::TGT_CORE, 8'h00);
        go(MR, 0, 17'h03FFF, 8'h00, addr_dec_pkg::TGT_SRAM, 8'h00);
        go(MR, 0, 17'h04000, 8'h00, addr_dec_pkg::TGT_FLASH, 8'h00);
        shared = 1'b0;
        strap = 1'b0;
        loaded = 1'b0;
        reset_dut();
        go(MR, 1, 17'h003D6, 8'h00, addr_dec_pkg::TGT_NONE, 8'h00);
        loaded = 1'b1;
        go(MR, 1, 17'h003D6, 8'h00, addr_dec_pkg::TGT_SRAM, 8'h00);
        go(MW, 1, 17'h00010, 8'hA5, addr_dec_pkg::TGT_NONE, 8'h00);
        go(MR, 1, 17'h01000, 8'h00, addr_dec_pkg::TGT_NONE, 8'h00);
        go(MR, 1, 17'h00FD0, 8'h00, addr_dec_pkg::TGT_CARD_REG, 8'h40);
        strap = 1'b1;
        go(MR, 1, 17'h00000, 8'h00, addr_dec_pkg::TGT_SRAM, 8'h00);
        check("strap map", 32'h0, fsel);
        repeat (10) @(posedge clk_i);
        check("pending", 32'h0, q.size());
        tally_and_finish();
    end
endmodule
